// ---- hdl/sst_defs.svh ----
// Constants of the setpoint tracker
`ifndef SST_DEFS_SVH
`define SST_DEFS_SVH
`define SST_POS_W 24
`define SST_POS_MAX 24'sh7F_FFFF
`define SST_POS_MIN (-24'sh7F_FFFF)
`define SST_POS_ZERO 24'sh00_0000
`define SST_PROD_W 42
`define SST_GEAR_W 16
`define SST_TABLE_DEPTH 64
`define SST_IDX_W 7
`define SST_ADDR_W 6
`define SST_IDX_FIRST 7'h01
`define SST_LEVEL_DEF 1'h0
`endif

// ---- hdl/sst_mem_if.sv ----
// Port bundle between the tracker and its target table
`include "sst_defs.svh"
interface sst_mem_if;
   logic wrEn;
   logic [`SST_ADDR_W-1:0] wrAddr;
   logic [`SST_POS_W-1:0] wrData;
   logic rdEn;
   logic [`SST_ADDR_W-1:0] rdAddr;
   logic [`SST_POS_W-1:0] rdData;
   logic clr;
   modport ctrl (output wrEn, output wrAddr, output wrData, output rdEn, output rdAddr,
      input rdData, output clr);
   modport mem (input wrEn, input wrAddr, input wrData, input rdEn, input rdAddr,
      output rdData, input clr);
endinterface : sst_mem_if

// ---- hdl/sst_pkg.sv ----
// Types of the setpoint tracker
`include "sst_defs.svh"
package sst_pkg;
   typedef logic signed [`SST_POS_W-1:0] sst_pos_t;
   typedef logic signed [`SST_PROD_W-1:0] sst_wide_t;
   typedef enum logic [2:0] {
      SST_SRC_HOLD = 3'b000,
      SST_SRC_HOME = 3'b001,
      SST_SRC_FREE = 3'b010,
      SST_SRC_WRITE = 3'b011,
      SST_SRC_ENC = 3'b100,
      SST_SRC_PROF = 3'b101
   } sst_src_t;
endpackage : sst_pkg

// ---- hdl/sst_target_mem.sv ----
// Stored target table, cleared in one cycle through per-entry valid bits
`include "sst_defs.svh"
module sst_target_mem #(
   parameter int DEPTH = `SST_TABLE_DEPTH
) (
   input wire logic ref_clk,
   sst_mem_if.mem port
);
   logic [`SST_POS_W-1:0] store [DEPTH];
   logic [DEPTH-1:0] valid_q;
   logic [`SST_POS_W-1:0] rdData_q;
   wire rdValid = valid_q[port.rdAddr];

   // Store array itself is never reset; valid bits give the zero default
   always_ff @(posedge ref_clk) begin
      if (port.wrEn) begin
         store[port.wrAddr] <= port.wrData;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (port.clr) begin
         valid_q <= '0;
      end else if (port.wrEn) begin
         valid_q[port.wrAddr] <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (port.rdEn) begin
         rdData_q <= rdValid ? store[port.rdAddr] : `SST_POS_ZERO;
      end
   end

   assign port.rdData = rdData_q;
endmodule : sst_target_mem

// ---- hdl/stepper_setpoint_tracker.sv ----
// Setpoint, feedback and error tracking with hold inputs and stored target table
// Operation
// R1 - Hold-release input polarity setting, default 0, 1 means active when closed; the code makes 1 active when the contact is open.
// R2 - Hold input polarity setting, default 0 normally open, 1 normally closed.
// R3 - New polarity stored at once but only used after next reset.
// R4 - Setpoint counter is signed, limited to plus or minus 8388607.
// R5 - Setpoint counter clears to zero at startup.
// R6 - Setpoint follows the motion profile generator in normal operation.
// R7 - With current off, setpoint keeps loading the feedback count.
// R8 - Successful home seek loads setpoint with zero.
// R9 - Direct setpoint write only accepted while no motion runs.
// R10 - Setpoint write shifts feedback by same amount, starts no motion.
// R11 - Setpoint write rescales encoder tally by gear ratio, and vice versa.
// R12 - Setpoint delta is change since motion start, zero at startup.
// R13 - Tracking error is setpoint minus feedback, computed continuously.
// R14 - Feedback count is encoder tally times ratio B over A.
// R15 - Feedback delta is change since motion start, zero at startup.
// R16 - Table of 64 signed targets indexed from 1, default zero, saved.
// R17 - Absolute move takes a table entry as its destination.
// R18 - Table clear zeroes every entry in one operation.
// R19 - Active hold input suspends motion like a hold command.
// R20 - Active hold-release input discards suspended motion like the command.
// R21 - All positions held as 24-bit two's complement values.
`include "sst_defs.svh"
module stepper_setpoint_tracker
   import sst_pkg::*;
#(
   parameter int GEAR_W = `SST_GEAR_W
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic porRst,
   input wire logic holdInput,
   input wire logic holdReleaseInput,
   input wire logic holdReleaseCmd,
   input wire logic holdLevelWr,
   input wire logic holdLevelWrData,
   input wire logic holdReleaseLevelWr,
   input wire logic holdReleaseLevelWrData,
   input wire logic motionActive,
   input wire logic motionStart,
   input wire logic currentOn,
   input wire logic homeDone,
   input wire logic profileValid,
   input wire sst_pos_t profileSetpoint,
   input wire logic setpointWr,
   input wire sst_pos_t setpointWrData,
   input wire logic encoderWr,
   input wire sst_pos_t encoderWrData,
   input wire logic encoderUp,
   input wire logic encoderDown,
   input wire logic [GEAR_W-1:0] gearRatioA,
   input wire logic [GEAR_W-1:0] gearRatioB,
   input wire logic tableWr,
   input wire logic [`SST_IDX_W-1:0] tableWrIndex,
   input wire sst_pos_t tableWrData,
   input wire logic targetTableClear,
   input wire logic absoluteMove,
   input wire logic [`SST_IDX_W-1:0] absoluteMoveIndex,
   output sst_pos_t setpointCounter_q,
   output sst_pos_t feedbackCount_q,
   output sst_pos_t trackingError_q,
   output sst_pos_t setpointDelta_q,
   output sst_pos_t feedbackDelta_q,
   output sst_pos_t encoderTally_q,
   output logic holdReq_q,
   output logic holdReleaseReq_q,
   output logic absMoveStart_q,
   output sst_pos_t absMoveTarget_q,
   output logic holdLevelStored_q,
   output logic holdReleaseLevelStored_q,
   output logic nvmSave_q
);
   // Multiply then divide, clamped to the legal position span
   function automatic sst_pos_t scaleSat(input sst_pos_t v, input logic [GEAR_W-1:0] mul,
         input logic [GEAR_W-1:0] dvd);
      sst_wide_t p;
      sst_wide_t q;
      p = sst_wide_t'(v) * sst_wide_t'({1'b0, mul});
      q = (dvd == '0) ? p : p / sst_wide_t'({1'b0, dvd});
      return clampPos(q);
   endfunction : scaleSat

   function automatic sst_pos_t clampPos(input sst_wide_t x);
      if (x > sst_wide_t'(`SST_POS_MAX)) begin
         return `SST_POS_MAX;
      end else if (x < sst_wide_t'(`SST_POS_MIN)) begin
         return `SST_POS_MIN;
      end
      return x[`SST_POS_W-1:0]; // R21
   endfunction : clampPos

   function automatic logic idxOk(input logic [`SST_IDX_W-1:0] idx);
      return idx >= `SST_IDX_FIRST && idx <= `SST_IDX_W'(`SST_TABLE_DEPTH);
   endfunction : idxOk

   // Pin synchronisers
   logic [1:0] holdSync_q;
   logic [1:0] relSync_q;
   logic holdActPrev_q;
   logic relActPrev_q;
   logic holdLevelActive_q;
   logic holdReleaseLevelActive_q;
   always_ff @(posedge ref_clk) begin
      holdSync_q <= {holdSync_q[0], holdInput};
      relSync_q <= {relSync_q[0], holdReleaseInput};
   end

   // Normally open: pin high when contact closed means active; closed level inverts
   wire holdAct = holdSync_q[1] ^ holdLevelActive_q; // R2
   wire relAct = relSync_q[1] ^ holdReleaseLevelActive_q; // R1

   // Stored image survives device reset, cleared only on power-on init
   always_ff @(posedge ref_clk) begin
      if (porRst) begin
         holdLevelStored_q <= `SST_LEVEL_DEF;
         holdReleaseLevelStored_q <= `SST_LEVEL_DEF;
      end else begin
         if (holdLevelWr) begin
            holdLevelStored_q <= holdLevelWrData; // R3
         end
         if (holdReleaseLevelWr) begin
            holdReleaseLevelStored_q <= holdReleaseLevelWrData; // R3
         end
      end
   end

   // Active levels only pick up the stored image at reset
   always_ff @(posedge ref_clk) begin
      if (rst || porRst) begin
         holdLevelActive_q <= porRst ? `SST_LEVEL_DEF : holdLevelStored_q; // R3
         holdReleaseLevelActive_q <= porRst ? `SST_LEVEL_DEF : holdReleaseLevelStored_q; // R3
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         holdActPrev_q <= 1'b1;
         relActPrev_q <= 1'b1;
         holdReq_q <= 1'b0;
         holdReleaseReq_q <= 1'b0;
      end else begin
         holdActPrev_q <= holdAct;
         relActPrev_q <= relAct;
         holdReq_q <= holdAct && !holdActPrev_q; // R19
         holdReleaseReq_q <= (relAct && !relActPrev_q) || holdReleaseCmd; // R20
      end
   end

   // Setpoint source selection
   wire wrOk = setpointWr && !motionActive; // R9
   wire encWrOk = encoderWr && !motionActive; // R9
   sst_src_t src;
   assign src = homeDone ? SST_SRC_HOME : !currentOn ? SST_SRC_FREE : wrOk ? SST_SRC_WRITE :
      encWrOk ? SST_SRC_ENC : profileValid ? SST_SRC_PROF : SST_SRC_HOLD;

   wire sst_wide_t wrDiff = sst_wide_t'(setpointWrData) - sst_wide_t'(setpointCounter_q);
   wire sst_wide_t encDiff = sst_wide_t'(encoderWrData) - sst_wide_t'(encoderTally_q);
   wire sst_pos_t tallyShift = scaleSat(clampPos(wrDiff), gearRatioA, gearRatioB);
   wire sst_pos_t pcShift = scaleSat(clampPos(encDiff), gearRatioB, gearRatioA);
   wire sst_wide_t stepTally = sst_wide_t'(encoderTally_q) +
      sst_wide_t'({1'b0, encoderUp}) - sst_wide_t'({1'b0, encoderDown});

   sst_pos_t setpoint_d;
   sst_pos_t tally_d;
   always_comb begin
      setpoint_d = setpointCounter_q;
      tally_d = clampPos(stepTally);
      case (src)
         SST_SRC_HOME: setpoint_d = `SST_POS_ZERO; // R8
         SST_SRC_FREE: setpoint_d = feedbackCount_q; // R7
         SST_SRC_WRITE: begin
            setpoint_d = setpointWrData; // R10
            tally_d = clampPos(sst_wide_t'(encoderTally_q) + sst_wide_t'(tallyShift)); // R11
         end
         SST_SRC_ENC: begin
            tally_d = encoderWrData;
            setpoint_d = clampPos(sst_wide_t'(setpointCounter_q) + sst_wide_t'(pcShift)); // R11
         end
         SST_SRC_PROF: setpoint_d = profileSetpoint; // R6
         SST_SRC_HOLD: setpoint_d = setpointCounter_q;
         default: setpoint_d = setpointCounter_q;
      endcase
   end

   sst_pos_t pcBase_q;
   sst_pos_t pfBase_q;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         setpointCounter_q <= `SST_POS_ZERO; // R5
         encoderTally_q <= `SST_POS_ZERO;
         feedbackCount_q <= `SST_POS_ZERO;
         trackingError_q <= `SST_POS_ZERO;
      end else begin
         setpointCounter_q <= clampPos(sst_wide_t'(setpoint_d)); // R4
         encoderTally_q <= tally_d;
         feedbackCount_q <= scaleSat(tally_d, gearRatioB, gearRatioA); // R14
         trackingError_q <= clampPos(sst_wide_t'(setpointCounter_q) -
            sst_wide_t'(feedbackCount_q)); // R13
      end
   end

   // Delta bases captured at each motion start; left as is after homing
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pcBase_q <= `SST_POS_ZERO;
         pfBase_q <= `SST_POS_ZERO;
         setpointDelta_q <= `SST_POS_ZERO;
         feedbackDelta_q <= `SST_POS_ZERO;
      end else begin
         if (motionStart) begin
            pcBase_q <= setpointCounter_q;
            pfBase_q <= feedbackCount_q;
         end
         setpointDelta_q <= motionStart ? `SST_POS_ZERO :
            clampPos(sst_wide_t'(setpointCounter_q) - sst_wide_t'(pcBase_q)); // R12
         feedbackDelta_q <= motionStart ? `SST_POS_ZERO :
            clampPos(sst_wide_t'(feedbackCount_q) - sst_wide_t'(pfBase_q)); // R15
      end
   end

   // Target table
   sst_mem_if memBus ();
   sst_target_mem #(.DEPTH(`SST_TABLE_DEPTH)) u_table (.ref_clk(ref_clk), .port(memBus.mem));
   wire tableWrOk = tableWr && idxOk(tableWrIndex);
   wire moveOk = absoluteMove && idxOk(absoluteMoveIndex);
   assign memBus.wrEn = tableWrOk && !porRst; // R16
   assign memBus.wrAddr = `SST_ADDR_W'(tableWrIndex - `SST_IDX_FIRST); // R16
   assign memBus.wrData = tableWrData;
   assign memBus.clr = targetTableClear || porRst; // R18
   assign memBus.rdEn = moveOk;
   assign memBus.rdAddr = `SST_ADDR_W'(absoluteMoveIndex - `SST_IDX_FIRST);

   logic moveRd_q;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         moveRd_q <= 1'b0;
         absMoveStart_q <= 1'b0;
         absMoveTarget_q <= `SST_POS_ZERO;
         nvmSave_q <= 1'b0;
      end else begin
         moveRd_q <= moveOk;
         absMoveStart_q <= moveRd_q; // R17
         if (moveRd_q) begin
            absMoveTarget_q <= memBus.rdData; // R17
         end
         nvmSave_q <= tableWrOk || targetTableClear || holdLevelWr || holdReleaseLevelWr; // R16
      end
   end

   property p_startup;
      @(posedge ref_clk) $fell(rst) |-> setpointCounter_q == `SST_POS_ZERO &&
         setpointDelta_q == `SST_POS_ZERO;
   endproperty
   a_startup: assert property (p_startup) else $error("setpoint not clear at startup"); // R5

   property p_span;
      @(posedge ref_clk) disable iff (rst)
         setpointCounter_q <= `SST_POS_MAX && setpointCounter_q >= `SST_POS_MIN;
   endproperty
   a_span: assert property (p_span) else $error("setpoint out of span"); // R4

   property p_home;
      @(posedge ref_clk) disable iff (rst) homeDone |=> setpointCounter_q == `SST_POS_ZERO;
   endproperty
   a_home: assert property (p_home) else $error("home did not zero setpoint"); // R8

   property p_freewheel;
      @(posedge ref_clk) disable iff (rst)
         !currentOn && !homeDone |=> setpointCounter_q == $past(feedbackCount_q);
   endproperty
   a_freewheel: assert property (p_freewheel) else $error("setpoint not tracking feedback"); // R7

   property p_wrLocked;
      @(posedge ref_clk) disable iff (rst)
         motionActive && currentOn && !homeDone && !profileValid |=>
         $stable(setpointCounter_q);
   endproperty
   a_wrLocked: assert property (p_wrLocked) else $error("setpoint changed during motion"); // R9

   property p_error;
      @(posedge ref_clk) disable iff (rst)
         $stable(setpointCounter_q) && $stable(feedbackCount_q) |=>
         trackingError_q == clampPos(sst_wide_t'($past(setpointCounter_q)) -
         sst_wide_t'($past(feedbackCount_q)));
   endproperty
   a_error: assert property (p_error) else $error("tracking error wrong"); // R13

   property p_absMove;
      @(posedge ref_clk) disable iff (rst) moveOk |-> ##2 absMoveStart_q;
   endproperty
   a_absMove: assert property (p_absMove) else $error("absolute move not started"); // R17

   property p_clear;
      @(posedge ref_clk) disable iff (rst)
         targetTableClear ##1 (moveOk && !tableWr) |-> ##2 absMoveTarget_q == `SST_POS_ZERO;
   endproperty
   a_clear: assert property (p_clear) else $error("table not cleared"); // R18

   property p_levelHeld;
      @(posedge ref_clk) disable iff (rst || porRst) ##1 $stable(holdLevelActive_q);
   endproperty
   a_levelHeld: assert property (p_levelHeld) else $error("hold level changed without reset"); // R3

   property p_hold;
      @(posedge ref_clk) disable iff (rst) $rose(holdAct) |=> holdReq_q;
   endproperty
   a_hold: assert property (p_hold) else $error("hold request missing"); // R19
endmodule : stepper_setpoint_tracker

// ---- tb/sst_enc_model.sv ----
// Shaft encoder model that emits count pulses on request
module sst_enc_model (
   input wire logic ref_clk,
   input wire logic go,
   input wire logic down,
   input wire logic [7:0] steps,
   output logic encoderUp,
   output logic encoderDown,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   // Half-step count, so pulses come every other cycle like a slow shaft
   logic [8:0] left = 9'h000;
   assign busy = left != 9'h000;
   always @(posedge ref_clk) begin
      encoderUp <= 1'b0;
      encoderDown <= 1'b0;
      if (go && !busy) begin
         left <= {steps, 1'b0};
      end else if (busy) begin
         left <= left - 9'h001;
         // Never both directions at once
         if (left[0]) begin
            encoderUp <= !down;
            encoderDown <= down;
         end
      end
   end
endmodule : sst_enc_model

// ---- tb/stepper_setpoint_tracker_tb.sv ----
// Self-checking bench of the setpoint tracker
module stepper_setpoint_tracker_tb
   import sst_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, rst = 1'b1, porRst = 1'b1;
   logic holdInput = 1'b0, holdReleaseInput = 1'b0, holdReleaseCmd = 1'b0;
   logic holdLevelWr = 1'b0, holdLevelWrData = 1'b0;
   logic holdReleaseLevelWr = 1'b0, holdReleaseLevelWrData = 1'b0;
   logic motionActive = 1'b0, motionStart = 1'b0, currentOn = 1'b1, homeDone = 1'b0;
   logic profileValid = 1'b0, setpointWr = 1'b0, encoderWr = 1'b0, tableWr = 1'b0;
   logic targetTableClear = 1'b0, absoluteMove = 1'b0, encGo = 1'b0, encNeg = 1'b0;
   logic encoderUp, encoderDown, encBusy, hit;
   logic [7:0] encSteps = 8'h00;
   logic [6:0] tableWrIndex = 7'h00, absoluteMoveIndex = 7'h00;
   // Fixed ratio: tally counts half of what feedback counts
   logic [15:0] gearRatioA = 16'h0001, gearRatioB = 16'h0002;
   sst_pos_t profileSetpoint = '0, setpointWrData = '0, encoderWrData = '0, tableWrData = '0;
   sst_pos_t setpointCounter_q, feedbackCount_q, trackingError_q, setpointDelta_q;
   sst_pos_t feedbackDelta_q, encoderTally_q, absMoveTarget_q;
   logic holdReq_q, holdReleaseReq_q, absMoveStart_q, nvmSave_q;
   logic holdLevelStored_q, holdReleaseLevelStored_q;
   logic [3:0] pv;
   int mismatches = 0, cmp_count = 0;
   assign pv = {nvmSave_q, absMoveStart_q, holdReleaseReq_q, holdReq_q};

   stepper_setpoint_tracker stepper_setpoint_tracker_i (.ref_clk, .rst, .porRst, .holdInput,
      .holdReleaseInput, .holdReleaseCmd, .holdLevelWr, .holdLevelWrData, .holdReleaseLevelWr,
      .holdReleaseLevelWrData, .motionActive, .motionStart, .currentOn, .homeDone,
      .profileValid, .profileSetpoint, .setpointWr, .setpointWrData, .encoderWr,
      .encoderWrData, .encoderUp, .encoderDown, .gearRatioA, .gearRatioB, .tableWr,
      .tableWrIndex, .tableWrData, .targetTableClear, .absoluteMove, .absoluteMoveIndex,
      .setpointCounter_q, .feedbackCount_q, .trackingError_q, .setpointDelta_q,
      .feedbackDelta_q, .encoderTally_q, .holdReq_q, .holdReleaseReq_q, .absMoveStart_q,
      .absMoveTarget_q, .holdLevelStored_q, .holdReleaseLevelStored_q, .nvmSave_q);
   sst_enc_model sst_enc_model_i (.ref_clk, .go(encGo), .down(encNeg), .steps(encSteps),
      .encoderUp, .encoderDown, .busy(encBusy));

   always #2 ref_clk = ~ref_clk;

   task step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : step
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %0d seen %0d", n, $signed(e), $signed(g));
      end
   endtask : chk
   // Pulses last one cycle, so every falling edge of the window is looked at
   task automatic seen(input int w);
      hit = 1'b0;
      repeat (8) begin
         if (pv[w] === 1'b1) hit = 1'b1;
         step(1);
      end
   endtask : seen
   task automatic encRun(input logic neg, input logic [7:0] n);
      encNeg = neg;
      encSteps = n;
      encGo = 1'b1;
      step(1);
      encGo = 1'b0;
      for (int i = 0; i < 600 && encBusy === 1'b1; i++) step(1);
      step(3);
   endtask : encRun
   task automatic mv(input logic [6:0] i);
      absoluteMoveIndex = i;
      absoluteMove = 1'b1;
      step(1);
      absoluteMove = 1'b0;
      seen(2);
   endtask : mv
   task summarize;
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   task t_reset;
      chk("setpoint", 24'h00_0000, setpointCounter_q);
      chk("setpoint delta", 24'h00_0000, setpointDelta_q);
      chk("feedback delta", 24'h00_0000, feedbackDelta_q);
      chk("hold level", 24'h00_0000, 24'(holdLevelStored_q));
      chk("release level", 24'h00_0000, 24'(holdReleaseLevelStored_q));
      $display("test reset done");
   endtask : t_reset
   task t_write;
      setpointWrData = 24'h00_0064;
      setpointWr = 1'b1;
      step(1);
      setpointWr = 1'b0;
      step(3);
      chk("setpoint", 24'h00_0064, setpointCounter_q);
      chk("tally", 24'h00_0032, encoderTally_q);
      chk("feedback", 24'h00_0064, feedbackCount_q);
      chk("error", 24'h00_0000, trackingError_q);
      encoderWrData = 24'h00_003C;
      encoderWr = 1'b1;
      step(1);
      encoderWr = 1'b0;
      step(3);
      chk("enc write setpoint", 24'h00_0078, setpointCounter_q);
      chk("enc write feedback", 24'h00_0078, feedbackCount_q);
      encoderWrData = 24'h00_0032;
      encoderWr = 1'b1;
      step(1);
      encoderWr = 1'b0;
      step(3);
      chk("enc write back", 24'h00_0064, setpointCounter_q);
      motionActive = 1'b1;
      setpointWrData = 24'h00_012C;
      setpointWr = 1'b1;
      step(1);
      setpointWr = 1'b0;
      step(3);
      chk("setpoint in motion", 24'h00_0064, setpointCounter_q);
      motionActive = 1'b0;
      $display("test write done");
   endtask : t_write
   task t_enc;
      encRun(1'b0, 8'h05);
      chk("tally", 24'h00_0037, encoderTally_q);
      chk("feedback", 24'h00_006E, feedbackCount_q);
      chk("error", 24'hFF_FFF6, trackingError_q);
      currentOn = 1'b0;
      encRun(1'b1, 8'h02);
      chk("freewheel setpoint", 24'h00_006A, setpointCounter_q);
      chk("freewheel error", 24'h00_0000, trackingError_q);
      currentOn = 1'b1;
      $display("test encoder done");
   endtask : t_enc
   task t_motion;
      homeDone = 1'b1;
      step(1);
      homeDone = 1'b0;
      step(3);
      chk("home setpoint", 24'h00_0000, setpointCounter_q);
      motionActive = 1'b1;
      motionStart = 1'b1;
      step(1);
      motionStart = 1'b0;
      step(2);
      profileSetpoint = 24'h00_03E8;
      profileValid = 1'b1;
      step(3);
      chk("profile setpoint", 24'h00_03E8, setpointCounter_q);
      chk("setpoint delta", 24'h00_03E8, setpointDelta_q);
      encRun(1'b0, 8'h03);
      chk("feedback delta", 24'h00_0006, feedbackDelta_q);
      profileSetpoint = 24'h80_0000;
      step(3);
      chk("clamped setpoint", 24'h80_0001, setpointCounter_q);
      profileValid = 1'b0;
      motionActive = 1'b0;
      $display("test motion done");
   endtask : t_motion
   task t_table;
      tableWrIndex = 7'h40;
      tableWrData = 24'h00_0070;
      tableWr = 1'b1;
      step(1);
      tableWr = 1'b0;
      seen(3);
      chk("table save", 24'h00_0001, 24'(hit));
      mv(7'h40);
      chk("move start", 24'h00_0001, 24'(hit));
      chk("move target", 24'h00_0070, absMoveTarget_q);
      mv(7'h01);
      chk("default entry", 24'h00_0000, absMoveTarget_q);
      mv(7'h00);
      chk("index zero", 24'h00_0000, 24'(hit));
      targetTableClear = 1'b1;
      step(1);
      targetTableClear = 1'b0;
      chk("clear save", 24'h00_0001, 24'(nvmSave_q));
      // Read right behind the clear, so a one-cycle clear must already show
      mv(7'h40);
      chk("cleared entry", 24'h00_0000, absMoveTarget_q);
      $display("test table done");
   endtask : t_table
   task t_hold;
      holdReleaseInput = 1'b1;
      seen(1);
      chk("release pin", 24'h00_0001, 24'(hit));
      holdReleaseInput = 1'b0;
      holdInput = 1'b1;
      seen(0);
      chk("hold pin", 24'h00_0001, 24'(hit));
      holdInput = 1'b0;
      seen(0);
      chk("hold pin open", 24'h00_0000, 24'(hit));
      holdLevelWrData = 1'b1;
      holdLevelWr = 1'b1;
      holdReleaseLevelWrData = 1'b1;
      holdReleaseLevelWr = 1'b1;
      step(1);
      holdLevelWr = 1'b0;
      holdReleaseLevelWr = 1'b0;
      seen(3);
      chk("level save", 24'h00_0001, 24'(hit));
      chk("hold level", 24'h00_0001, 24'(holdLevelStored_q));
      chk("release level", 24'h00_0001, 24'(holdReleaseLevelStored_q));
      // New polarity must wait for the next reset
      holdInput = 1'b1;
      seen(0);
      chk("old polarity", 24'h00_0001, 24'(hit));
      holdInput = 1'b0;
      seen(0);
      chk("old polarity open", 24'h00_0000, 24'(hit));
      holdReleaseCmd = 1'b1;
      step(1);
      holdReleaseCmd = 1'b0;
      seen(1);
      chk("release cmd", 24'h00_0001, 24'(hit));
      rst = 1'b1;
      step(3);
      rst = 1'b0;
      step(8);
      chk("level kept", 24'h00_0001, 24'(holdLevelStored_q));
      holdInput = 1'b1;
      seen(0);
      chk("closed polarity", 24'h00_0000, 24'(hit));
      holdInput = 1'b0;
      seen(0);
      chk("closed polarity open", 24'h00_0001, 24'(hit));
      $display("test hold done");
   endtask : t_hold

   initial begin
      step(3);
      rst = 1'b0;
      porRst = 1'b0;
      step(1);
      t_reset;
      t_write;
      t_enc;
      t_motion;
      t_table;
      t_hold;
      summarize;
   end
   // All tests take well under a thousand cycles
   initial begin
      repeat (4000) @(posedge ref_clk);
      mismatches++;
      summarize;
   end
endmodule : stepper_setpoint_tracker_tb
